//--- shared/cbma_pkg.sv
// Package for the cluster bus master arbiter: widths, address map, latencies
// and the packed request and answer carriers.
// Assumes a single cluster clock shared by host, sequencer and targets.
package cbma_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BUF_DEPTH = 2;

    // Wait cycles per target class; total bus cycles are waits plus one.
    localparam logic [3:0] WAIT_ZERO = 4'h0;
    localparam logic [3:0] WAIT_ONE = 4'h1;
    localparam logic [3:0] WAIT_MULTI = 4'h3;

    // Address map, as base and mask pairs.
    localparam logic [15:0] CONV_BASE = 16'hF000;
    localparam logic [15:0] CONV_MASK = 16'hF000;
    localparam logic [15:0] SEQ_MEM_BASE = 16'hC000;
    localparam logic [15:0] SEQ_MEM_MASK = 16'hF000;
    localparam logic [15:0] BUF_MEM_BASE = 16'hD000;
    localparam logic [15:0] BUF_MEM_MASK = 16'hF000;
    localparam logic [15:0] ANGLE_MEM_BASE = 16'hE000;
    localparam logic [15:0] ANGLE_MEM_MASK = 16'hF000;
    localparam logic [15:0] SEQ_TRIG_BASE = 16'h0A00;
    localparam logic [15:0] SEQ_TRIG_MASK = 16'hFFF8;
    localparam logic [15:0] ONE_WAIT_BASE = 16'h0100;
    localparam logic [15:0] ONE_WAIT_MASK = 16'hFFC0;

    // Answer status codes.
    localparam logic [1:0] STS_OK = 2'h0;
    localparam logic [1:0] STS_DENIED = 2'h2;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0] thread;
    } cbma_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] status;
        logic [DATA_W-1:0] rdata;
        logic [2:0] thread;
    } cbma_rsp_t;

    typedef enum logic [1:0] {
        CBMA_OWN_NONE,
        CBMA_OWN_CPU,
        CBMA_OWN_SEQ
    } cbma_own_t;

endpackage : cbma_pkg

//--- core/cbma_arbiter.sv
// Cluster bus master arbiter: grants the cluster register bus to the host or
// to the sequencer master port, buffers delayed sequencer accesses and sends
// converter accesses straight through with zero wait.
// Assumes targets answer in the modelled wait count; single clock domain.
// Assumes the host holds off while cpu_busy is high and the sequencer only
// offers a request while seq_ready is high; read data from the cluster bus
// is taken on the last cycle of the access.
// Contract
// - Sequencer requests win the cluster bus over CPU requests.
// - Access lasts one, two or several cycles for zero, one, multi wait.
// - Ordinary registers and converter reads answer with zero wait.
// - Listed special control registers need exactly one wait cycle.
// - Memories and two sequencer trigger registers need several wait cycles.
// - Sequencer port cannot reach buffer memory or sequencer program memory.
// - Delayed sequencer accesses are held in master-port buffers.
// - Converter accesses use the same sequencer port and interfaces.
// - Converter accesses recognised by address range and forwarded out.
// - Converter accesses are zero wait and bypass the buffers.
// - After a delaying CPU access ends, the buffered access runs.
// - Routing-unit traffic is independent of master-port traffic.
`timescale 1ns/1ps
module cbma_arbiter
    import cbma_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire cbma_req_t cpu_req,
    output cbma_rsp_t cpu_rsp,
    output logic cpu_busy,
    input wire cbma_req_t seq_req,
    output logic seq_ready,
    output cbma_rsp_t seq_rsp,
    input wire logic master_port_disable,
    output cbma_req_t bus_req,
    input wire logic [DATA_W-1:0] bus_rdata,
    output cbma_req_t conv_req,
    input wire logic [DATA_W-1:0] conv_rdata
);

    // Address classification, used for both requesters. The slow classes are
    // tested first so that a memory never falls into a faster class by an
    // overlapping mask.
    function automatic logic [3:0] wait_of(input logic [ADDR_W-1:0] a);
        if ((a & SEQ_MEM_MASK) == SEQ_MEM_BASE
            || (a & BUF_MEM_MASK) == BUF_MEM_BASE
            || (a & ANGLE_MEM_MASK) == ANGLE_MEM_BASE
            || (a & SEQ_TRIG_MASK) == SEQ_TRIG_BASE) begin
            return WAIT_MULTI;
        end else if ((a & ONE_WAIT_MASK) == ONE_WAIT_BASE) begin
            return WAIT_ONE;
        end
        return WAIT_ZERO;
    endfunction : wait_of

    function automatic logic is_conv(input logic [ADDR_W-1:0] a);
        return (a & CONV_MASK) == CONV_BASE;
    endfunction : is_conv

    function automatic logic seq_forbidden(input logic [ADDR_W-1:0] a);
        return (a & SEQ_MEM_MASK) == SEQ_MEM_BASE
            || (a & BUF_MEM_MASK) == BUF_MEM_BASE;
    endfunction : seq_forbidden

    // Buffer storage and bus ownership state.
    cbma_req_t buf_ff [BUF_DEPTH];
    cbma_req_t nxt_buf [BUF_DEPTH];
    logic [1:0] cnt_ff, nxt_cnt;
    logic rd_ff, nxt_rd;
    logic wr_ff, nxt_wr;
    cbma_own_t own_ff, nxt_own;
    cbma_req_t cur_ff, nxt_cur;
    logic [3:0] wait_ff, nxt_wait;
    cbma_req_t cpu_hold_ff, nxt_cpu_hold;
    cbma_rsp_t cpu_rsp_ff, nxt_cpu_rsp;
    cbma_rsp_t seq_rsp_ff, nxt_seq_rsp;
    cbma_req_t bus_ff, nxt_bus;
    cbma_req_t conv_ff, nxt_conv;
    logic seq_rdy_ff, nxt_seq_rdy;

    // Request decode for the current cycle. A request counts as taken only
    // when the port is ready and enabled, so a request held over several ready
    // cycles is taken once in each of them.
    logic seq_take, seq_is_conv, seq_bad;
    logic bus_idle, done;
    logic pop_seen;

    assign seq_take = seq_req.valid && seq_rdy_ff && !master_port_disable;
    assign seq_is_conv = is_conv(seq_req.addr);
    assign seq_bad = seq_forbidden(seq_req.addr);
    assign bus_idle = (own_ff == CBMA_OWN_NONE);
    assign done = !bus_idle && (wait_ff == WAIT_ZERO);
    // Whether a buffered entry leaves the buffer in this cycle.
    assign pop_seen = (bus_idle || done) && cnt_ff != 2'h0;

    // Arbitration, buffering and answer generation in one next-state step.
    always_comb begin
        cbma_req_t head;
        logic pop;
        logic push;
        logic seq_answering;
        head = buf_ff[rd_ff];
        pop = 1'b0;
        push = 1'b0;
        seq_answering = 1'b0;
        nxt_buf = buf_ff;
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_own = own_ff;
        nxt_cur = cur_ff;
        nxt_wait = wait_ff;
        nxt_cpu_hold = cpu_hold_ff;
        nxt_cpu_rsp = '0;
        nxt_seq_rsp = '0;
        nxt_bus = '0;
        nxt_conv = '0;
        // Latch a CPU request; the host holds off while busy.
        if (cpu_req.valid && !cpu_hold_ff.valid) begin
            nxt_cpu_hold = cpu_req;
        end
        // Count down the running access; answer when the count runs out.
        if (!bus_idle) begin
            if (wait_ff != WAIT_ZERO) begin
                nxt_wait = wait_ff - 4'h1;
            end else begin
                nxt_own = CBMA_OWN_NONE;
                if (own_ff == CBMA_OWN_CPU) begin
                    nxt_cpu_rsp = '{1'b1, STS_OK, bus_rdata, cur_ff.thread};
                    nxt_cpu_hold = '0;
                end else begin
                    nxt_seq_rsp = '{1'b1, STS_OK, bus_rdata, cur_ff.thread};
                end
            end
        end
        // Converter accesses skip the buffers and the bus entirely.
        if (seq_take && seq_is_conv) begin
            nxt_conv = seq_req;
            nxt_seq_rsp = '{1'b1, STS_OK, conv_rdata, seq_req.thread};
        end else if (seq_take && seq_bad) begin
            nxt_seq_rsp = '{1'b1, STS_DENIED, '0, seq_req.thread};
        end else if (seq_take) begin
            push = 1'b1;
        end
        // Grant a free bus: buffered sequencer work first, then the host.
        // A host access that ends in this cycle is not granted again, since
        // its hold register is cleared at the same edge.
        if (bus_idle || done) begin
            if (cnt_ff != 2'h0) begin
                pop = 1'b1;
                nxt_own = CBMA_OWN_SEQ;
                nxt_cur = head;
                nxt_wait = wait_of(head.addr);
                nxt_bus = head;
            end else if (cpu_hold_ff.valid && !(done
                && own_ff == CBMA_OWN_CPU)) begin
                nxt_own = CBMA_OWN_CPU;
                nxt_cur = cpu_hold_ff;
                nxt_wait = wait_of(cpu_hold_ff.addr);
                nxt_bus = cpu_hold_ff;
            end
        end
        // A push lands in the write slot, so a pending head is kept.
        if (push) begin
            nxt_buf[wr_ff] = seq_req;
            nxt_wr = ~wr_ff;
        end
        if (pop) begin
            nxt_rd = ~rd_ff;
        end
        nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
        // Ready drops when both slots would be full, and also for the one
        // cycle in which a sequencer bus access answers: the answer port has
        // a single slot, so a converter or refused answer taken then would
        // overwrite the bus answer and the thread would lose its data. This
        // trades some port throughput for answers that are never dropped.
        seq_answering = (nxt_own == CBMA_OWN_SEQ) && (nxt_wait == WAIT_ZERO);
        nxt_seq_rdy = !master_port_disable && (nxt_cnt < 2'(BUF_DEPTH))
            && !seq_answering;
    end

    // State registers only; every decision is made in the process above.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_ff[i] <= '0;
            end
            cnt_ff <= 2'h0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            own_ff <= CBMA_OWN_NONE;
            cur_ff <= '0;
            wait_ff <= WAIT_ZERO;
            cpu_hold_ff <= '0;
            cpu_rsp_ff <= '0;
            seq_rsp_ff <= '0;
            bus_ff <= '0;
            conv_ff <= '0;
            seq_rdy_ff <= 1'b0;
        end else begin
            buf_ff <= nxt_buf;
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            own_ff <= nxt_own;
            cur_ff <= nxt_cur;
            wait_ff <= nxt_wait;
            cpu_hold_ff <= nxt_cpu_hold;
            cpu_rsp_ff <= nxt_cpu_rsp;
            seq_rsp_ff <= nxt_seq_rsp;
            bus_ff <= nxt_bus;
            conv_ff <= nxt_conv;
            seq_rdy_ff <= nxt_seq_rdy;
        end
    end

    // Outputs all come from flip-flops. The routing unit is not involved here,
    // so its traffic never sees this port's stalls.
    assign cpu_rsp = cpu_rsp_ff;
    assign cpu_busy = cpu_hold_ff.valid;
    assign seq_ready = seq_rdy_ff;
    assign seq_rsp = seq_rsp_ff;
    assign bus_req = bus_ff;
    assign conv_req = conv_ff;

    // Checks next to the logic they guard. Most sample only the registered
    // state; those on seq_take or master_port_disable also sample port inputs.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_grant_zero;
        bus_ff.valid && wait_of(bus_ff.addr) == WAIT_ZERO;
    endsequence

    chk_zero_wait_answer: assert property (
        s_grant_zero |=> (cpu_rsp_ff.valid || seq_rsp_ff.valid))
        else $error("zero wait access did not answer next cycle");
    chk_one_wait_answer: assert property (
        bus_ff.valid && wait_of(bus_ff.addr) == WAIT_ONE
        |=> !(cpu_rsp_ff.valid && own_ff == CBMA_OWN_NONE) ##1
            (cpu_rsp_ff.valid || seq_rsp_ff.valid))
        else $error("one wait access answer timing wrong");
    chk_multi_wait_len: assert property (
        bus_ff.valid && wait_of(bus_ff.addr) == WAIT_MULTI
        |=> !bus_idle [*3] ##1 (cpu_rsp_ff.valid || seq_rsp_ff.valid))
        else $error("multi wait access length wrong");
    chk_seq_priority: assert property (
        (bus_idle || done) && cnt_ff != 2'h0 |=> own_ff == CBMA_OWN_SEQ)
        else $error("buffered sequencer access lost arbitration");
    chk_forbidden_block: assert property (
        seq_take && seq_bad && !seq_is_conv
        |=> seq_rsp_ff.status == STS_DENIED && seq_rsp_ff.valid)
        else $error("forbidden region not refused");
    chk_conv_bypass: assert property (
        seq_take && seq_is_conv |=> conv_ff.valid && seq_rsp_ff.valid
            && cnt_ff == $past(cnt_ff) - {1'b0, $past(pop_seen)})
        else $error("converter access not passed straight through");
    chk_buffer_hold: assert property (
        seq_take && !seq_is_conv && !seq_bad && !bus_idle && !done
        |=> cnt_ff != 2'h0)
        else $error("delayed sequencer access not buffered");
    chk_after_cpu: assert property (
        done && own_ff == CBMA_OWN_CPU && cnt_ff != 2'h0
        |=> bus_ff.valid && own_ff == CBMA_OWN_SEQ)
        else $error("buffered access did not follow host access");
    chk_no_overflow: assert property (
        cnt_ff <= 2'(BUF_DEPTH))
        else $error("buffer count overran");

    // A buffered answer and a direct answer must never meet in one cycle.
    chk_rsp_no_clash: assert property (
        done && own_ff == CBMA_OWN_SEQ |-> !seq_take)
        else $error("sequencer answers collided");
    // Once the host access ends, the host is answered and free to send again.
    chk_host_release: assert property (
        done && own_ff == CBMA_OWN_CPU |=> !cpu_busy && cpu_rsp_ff.valid)
        else $error("host access did not release");
    // The disabled port takes no request at once and drops seq_ready from the next cycle on.
    chk_port_off: assert property (
        master_port_disable |=> !seq_ready)
        else $error("disabled port still ready");
    // Converter traffic never reaches the cluster bus itself.
    chk_conv_not_bus: assert property (
        seq_take && seq_is_conv && !pop_seen && !cpu_hold_ff.valid
        |=> !bus_ff.valid)
        else $error("converter access leaked onto the cluster bus");

endmodule : cbma_arbiter

//--- tb/cbma_target_model.sv
// Target model: cluster bus targets with address-based wait cycles, and a
// converter. Assumes the arbiter's single clock and synchronous reset.
`timescale 1ns/1ps
module cbma_target_model
    import cbma_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire cbma_req_t bus_req,
    output logic [DATA_W-1:0] bus_rdata,
    input wire cbma_req_t seq_req,
    output logic [DATA_W-1:0] conv_rdata
);
    logic [3:0] left_ff;
    logic [ADDR_W-1:0] addr_ff;

    // Wait class by address; memories, the converter range and the triggers are the slow ones.
    function automatic logic [3:0] waits(input logic [ADDR_W-1:0] a);
        if ((a & SEQ_TRIG_MASK) == SEQ_TRIG_BASE || a[15:12] >= 4'hC)
            return WAIT_MULTI;
        if ((a & ONE_WAIT_MASK) == ONE_WAIT_BASE)
            return WAIT_ONE;
        return WAIT_ZERO;
    endfunction : waits

    // Count the open access down so that stale data is never offered.
    always_ff @(posedge clk) begin
        if (reset) begin
            left_ff <= 4'h0;
            addr_ff <= 16'h0000;
        end else if (bus_req.valid) begin
            left_ff <= waits(bus_req.addr) + 4'h1;
            addr_ff <= bus_req.addr;
        end else if (left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
    end

    // Outside an access the lines show the inverse pattern, not old data.
    assign bus_rdata = bus_req.valid ? {16'hA5A5, bus_req.addr} :
        (left_ff != 4'h0) ? {16'hA5A5, addr_ff} : ~{16'hA5A5, addr_ff};
    // The converter answers at once, with no wait.
    assign conv_rdata = seq_req.valid ? {16'h5A5A, seq_req.addr} :
        ~{16'h5A5A, seq_req.addr};
endmodule : cbma_target_model

//--- tb/test_cluster_bus_master_arbiter.sv
// Testbench for the arbiter: host and sequencer traffic against the model.
// Assumes a 200 MHz clock and synchronous active high reset.
`timescale 1ns/1ps
module test_cluster_bus_master_arbiter;
    import cbma_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic master_port_disable = 1'b0;
    logic seq_ready;
    logic cpu_busy;
    cbma_req_t cpu_req = '0;
    cbma_req_t seq_req = '0;
    cbma_req_t bus_req;
    cbma_req_t conv_req;
    cbma_rsp_t cpu_rsp;
    cbma_rsp_t seq_rsp;
    logic [DATA_W-1:0] bus_rdata;
    logic [DATA_W-1:0] conv_rdata;
    int error_cnt = 0;
    int compares = 0;
    logic [31:0] cyc = 32'h0;
    logic [63:0] rq[$];
    logic [47:0] bq[$];
    logic [15:0] cq[$];

    always #2.5 clk = ~clk;

    cbma_arbiter u_cbma_arbiter (.clk(clk), .reset(reset),
        .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_busy(cpu_busy),
        .seq_req(seq_req), .seq_ready(seq_ready), .seq_rsp(seq_rsp),
        .master_port_disable(master_port_disable), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .conv_req(conv_req), .conv_rdata(conv_rdata));
    cbma_target_model u_cbma_target_model (.clk(clk), .reset(reset),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .seq_req(seq_req),
        .conv_rdata(conv_rdata));

    // Record every sequencer answer and every issued access; pulses last one cycle.
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        if (seq_rsp.valid === 1'b1)
            rq.push_back({27'h0, seq_rsp.status, seq_rsp.thread, seq_rsp.rdata});
        if (bus_req.valid === 1'b1) bq.push_back({cyc, bus_req.addr});
        if (conv_req.valid === 1'b1) cq.push_back(conv_req.addr);
    end

    task automatic report_and_stop;
        $display("error_cnt=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // Bounded wait for enough answers and accesses; a hang ends the run.
    task automatic wait_q(input int nr, input int nb);
        for (int i = 0; i < 80; i++) begin
            if (rq.size() >= nr && bq.size() >= nb) return;
            @(posedge clk);
        end
        chk({32'(rq.size()), 32'(bq.size())}, {32'(nr), 32'(nb)});
        report_and_stop();
    endtask : wait_q

    task automatic idle;
        repeat (10) @(posedge clk);
        rq.delete();
        bq.delete();
        cq.delete();
    endtask : idle

    task automatic seq_send(input logic [15:0] a, input logic [2:0] th);
        seq_req <= '{1'b1, 1'b0, a, 32'h0, th};
        @(posedge clk);
    endtask : seq_send

    // Host read; the latency figure follows the wait class of the target.
    task automatic host_rd(input logic [15:0] a, input logic [3:0] w);
        int n = 0;
        cpu_req <= '{1'b1, 1'b0, a, 32'h0, 3'h0};
        @(posedge clk);
        cpu_req.valid <= 1'b0;
        while (n < 40 && cpu_rsp.valid !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(64'(n), 64'(2 + w));
        chk(64'(cpu_rsp.rdata), {32'h0, 16'hA5A5, a});
        if (n >= 40) report_and_stop();
        @(posedge clk);
    endtask : host_rd

    task automatic t_conv;
        idle();
        seq_send(16'hF010, 3'h2);
        seq_req.valid <= 1'b0;
        wait_q(1, 0);
        chk(rq[0], {27'h0, STS_OK, 3'h2, 32'h5A5AF010});
        chk(64'(cq.size()), 64'h1);
        chk(64'(bq.size()), 64'h0);
    endtask : t_conv

    // Program and buffer memory are out of the sequencer's reach.
    task automatic t_refuse;
        logic [15:0] a[2] = '{16'hC004, 16'hD004};
        foreach (a[i]) begin
            idle();
            seq_send(a[i], 3'h1);
            seq_req.valid <= 1'b0;
            wait_q(1, 0);
            chk(64'(rq[0][36:35]), 64'(STS_DENIED));
            chk(64'(bq.size()), 64'h0);
        end
    endtask : t_refuse

    // Host and sequencer collide; a second sequencer access follows at once.
    task automatic t_prio;
        idle();
        cpu_req <= '{1'b1, 1'b0, 16'h0020, 32'h0, 3'h0};
        seq_send(16'h0030, 3'h4);
        cpu_req.valid <= 1'b0;
        seq_send(16'h0104, 3'h5);
        seq_req.valid <= 1'b0;
        wait_q(2, 3);
        chk(64'(bq[0][15:0]), 64'h0030);
        chk(64'(bq[1][15:0]), 64'h0104);
        chk(64'(bq[2][15:0]), 64'h0020);
        chk(rq[0], {27'h0, STS_OK, 3'h4, 32'hA5A50030});
        chk(rq[1], {27'h0, STS_OK, 3'h5, 32'hA5A50104});
    endtask : t_prio

    // A slow host access holds the bus; the sequencer access must wait.
    task automatic t_cpu_first;
        idle();
        cpu_req <= '{1'b1, 1'b0, 16'hE010, 32'h0, 3'h0};
        @(posedge clk);
        cpu_req.valid <= 1'b0;
        repeat (2) @(posedge clk);
        seq_send(16'h0040, 3'h6);
        seq_req.valid <= 1'b0;
        wait_q(1, 2);
        chk(64'(bq[1][15:0]), 64'h0040);
        chk(64'(bq[1][47:16] - bq[0][47:16] >= 32'h4), 64'h1);
        chk(rq[0], {27'h0, STS_OK, 3'h6, 32'hA5A50040});
    endtask : t_cpu_first

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        host_rd(16'h0010, WAIT_ZERO);
        host_rd(16'h0104, WAIT_ONE);
        host_rd(16'hE008, WAIT_MULTI);
        host_rd(16'h0A04, WAIT_MULTI);
        t_conv();
        t_refuse();
        t_prio();
        t_cpu_first();
        idle();
        master_port_disable <= 1'b1;
        repeat (3) @(posedge clk);
        chk(64'(seq_ready), 64'h0);
        report_and_stop();
    end
endmodule : test_cluster_bus_master_arbiter
